/* design/dac_link_if.sv */
// Purpose: Serial link between word sender and converter word loader
// Assumes: Sender makes the bit clock and drives all three wires
// Notes:   No two-way wires
`timescale 1ns/10ps
interface dac_link_if;
    logic bclk;
    logic word_load_strobe;
    logic sdata;

    modport ctrl (
        output bclk,
        output word_load_strobe,
        output sdata
    );

    modport dac (
        input bclk,
        input word_load_strobe,
        input sdata
    );
endinterface

/* design/dac_link_pkg.sv */
// Purpose: Shared constants and types for the serial audio word link
// Assumes: 25 MHz system clock, 16-bit two's complement words
// Notes:   Slot length is sized to sustain two channels at 176.4 kHz
package dac_link_pkg;

    localparam int WORD_W = 16;
    localparam int CHANNELS = 2;
    localparam int CLK_SYS_HZ = 25_000_000;
    localparam int CLK_SYS_NS = 40;
    localparam int SAMPLE_HZ = 176_400;
    // Longest slot that keeps the rate: rounds down
    localparam int SLOT_CYC = CLK_SYS_HZ / (CHANNELS * SAMPLE_HZ);
    localparam int BCLK_DIV = 2;
    localparam int SLOT_BITS = SLOT_CYC / BCLK_DIV;
    // Strobe falls on the bit slot after the last data bit
    localparam int LOAD_BIT = WORD_W;
    // Settle time before closing a channel switch: rounds up
    localparam int SETTLE_NS = 1500;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic {CH_LEFT, CH_RIGHT} chan_e;

endpackage

/* design/dac_word_loader.sv */
// Purpose: Converter end: serial shift register and input register
// Assumes: Runs wholly on the link bit clock; ce is from that domain
// Notes:   No reset; contents undefined until the first full word
`timescale 1ns/10ps
module dac_word_loader
    import dac_link_pkg::*;
(
    // Link
    dac_link_if.dac link,
    // Clock enable, bit clock domain
    input wire logic ce,
    // Converter input
    output logic [WORD_W-1:0] dac_word,
    output logic dac_update
);
    logic din_r;
    logic strobe_r;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic load;

    // Input stage delays each bit one edge, so a 17th edge is needed
    assign shift_nxt = {shift_r[WORD_W-2:0], din_r};
    assign load = strobe_r && !link.word_load_strobe;

    ////////////////////////////////////////////////////////////////////////
    // Serial input, MSB first, oldest bits fall off the top
    always_ff @(posedge link.bclk) begin
        if (ce) begin
            din_r <= link.sdata;
            shift_r <= shift_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe edge detect
    always_ff @(posedge link.bclk) begin
        if (ce) begin
            strobe_r <= link.word_load_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input register, changes only on a strobe fall
    always_ff @(posedge link.bclk) begin
        if (ce && load) begin
            dac_word <= shift_nxt;
        end
    end

    always_ff @(posedge link.bclk) begin
        if (ce) begin
            dac_update <= load;
        end
    end
endmodule

/* design/dac_word_sender.sv */
// Purpose: Controller end: bit clock, strobe and data for the converter
// Assumes: 25 MHz clk_sys; bit clock is clk_sys divided by two
// Notes:   Alternates left/right words; drives one sample switch each
`timescale 1ns/10ps

module dac_word_sender
    import dac_link_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int SETTLE = SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Sample words in, left first then right
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WORD_W-1:0] s_data,
    // Deglitcher switch controls, high closes the switch
    output logic sample_left,
    output logic sample_right,
    // Status
    output logic slot_busy,
    output logic underrun,
    // Link
    dac_link_if.ctrl link
);
    localparam int KW = $clog2(SLOT_BITS + 1);
    localparam int SW = $clog2(SETTLE + 1);
    localparam logic [KW-1:0] K_LOAD = KW'(LOAD_BIT);
    localparam logic [KW-1:0] K_LAST = KW'(SLOT_BITS - 1);
    localparam logic [SW-1:0] SETTLE_INIT = SW'(SETTLE);

    typedef enum {ST_IDLE, ST_SLOT} slot_state_e;

    slot_state_e state_r;
    logic bclk_r;
    logic strobe_r;
    logic sdata_r;
    logic [WORD_W-1:0] word_r;
    logic [KW-1:0] bit_r;
    logic [SW-1:0] settle_r;
    chan_e ch_r;
    chan_e upd_ch_r;
    logic [CHANNELS-1:0] sample_r;
    logic started_r;
    logic underrun_r;
    logic fall;
    logic start;
    logic load_fall;
    logic settled;
    logic f_valid;
    logic f_ready;
    logic [WORD_W-1:0] f_data;

    ////////////////////////////////////////////////////////////////////////
    // Word buffer
    sample_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .in_valid(s_valid),
        .in_ready(s_ready),
        .in_data(s_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // Data changes as the bit clock falls, converter samples on the rise
    assign fall = ce && bclk_r;
    assign start = fall && (state_r == ST_IDLE) && f_valid;
    assign f_ready = start;
    assign load_fall = fall && (state_r == ST_SLOT) && (bit_r == K_LOAD);
    assign settled = ce && (settle_r == SW'(1));

    assign link.bclk = bclk_r;
    assign link.word_load_strobe = strobe_r;
    assign link.sdata = sdata_r;
    assign sample_left = sample_r[CH_LEFT];
    assign sample_right = sample_r[CH_RIGHT];
    assign slot_busy = (state_r == ST_SLOT);
    assign underrun = underrun_r;

    ////////////////////////////////////////////////////////////////////////
    // Bit clock divider, runs free
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bclk_r <= 1'b0;
        end else if (ce) begin
            bclk_r <= ~bclk_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else if (fall) begin
            case (state_r)
                ST_IDLE: begin
                    if (f_valid) begin
                        state_r <= ST_SLOT;
                    end
                end
                ST_SLOT: begin
                    if (bit_r == K_LAST) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bit_r <= '0;
        end else if (start) begin
            bit_r <= KW'(1);
        end else if (fall && state_r == ST_SLOT) begin
            bit_r <= bit_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial data, MSB first, zeros after the word
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sdata_r <= 1'b0;
            word_r <= '0;
        end else if (start) begin
            sdata_r <= f_data[WORD_W-1];
            word_r <= {f_data[WORD_W-2:0], 1'b0};
        end else if (fall && state_r == ST_SLOT) begin
            sdata_r <= word_r[WORD_W-1];
            word_r <= {word_r[WORD_W-2:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe: high over the 16 data bits, falls on the 17th edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            strobe_r <= 1'b0;
        end else if (start) begin
            strobe_r <= 1'b1;
        end else if (load_fall) begin
            strobe_r <= 1'b0;
        end else if (fall && state_r == ST_IDLE) begin
            strobe_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel alternation
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ch_r <= CH_LEFT;
            upd_ch_r <= CH_LEFT;
        end else if (load_fall) begin
            upd_ch_r <= ch_r;
            ch_r <= (ch_r == CH_LEFT) ? CH_RIGHT : CH_LEFT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settle delay after each update
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            settle_r <= '0;
        end else if (load_fall) begin
            settle_r <= SETTLE_INIT;
        end else if (ce && settle_r != '0) begin
            settle_r <= settle_r - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Deglitcher switches: both open on update, one closes when settled
    for (genvar c = 0; c < CHANNELS; c++) begin : g_switch
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                sample_r[c] <= 1'b0;
            end else if (load_fall) begin
                sample_r[c] <= 1'b0;
            end else if (settled && upd_ch_r == chan_e'(c)) begin
                sample_r[c] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Underrun: a slot boundary with no word waiting after streaming began
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            started_r <= 1'b0;
        end else if (start) begin
            started_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            underrun_r <= 1'b0;
        end else if (ce) begin
            underrun_r <= fall && started_r && (state_r == ST_IDLE) &&
                          !f_valid;
        end
    end
endmodule

/* design/sample_fifo.sv */
// Purpose: Word FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Depth must be a power of two
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) ||
                      (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;
    assign out_data = mem[rd_ptr_r[AW-1:0]];

    ////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_ptr_r <= '0;
        end else if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule

/* verif/dac_link_asserts.sv */
// Purpose: Link and switch checks for the serial word link
// Assumes: ce held high; all sampled on clk_sys
// Notes:   Counters stand in for long repetitions
`timescale 1ns/10ps
module dac_link_asserts #(
    parameter int SETTLE = 38
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Link
    input wire logic bclk,
    input wire logic word_load_strobe,
    input wire logic sdata,
    // Switches
    input wire logic sample_left,
    input wire logic sample_right
);
    logic [7:0] hi_r;
    logic [7:0] lo_r;
    logic left_last_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////
    // Strobe high and low cycle counts
    always_ff @(posedge clk_sys) begin
        hi_r <= (!nrst || !word_load_strobe) ? 8'h00 : hi_r + 8'h01;
    end
    always_ff @(posedge clk_sys) begin
        lo_r <= (!nrst || word_load_strobe) ? 8'h00 :
            lo_r + {7'h00, lo_r != 8'hff};
    end
    // Channel of the last switch closed
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            left_last_r <= 1'b0;
        end else if ($rose(sample_left) || $rose(sample_right)) begin
            left_last_r <= sample_left;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_bclk_div;
        $past(nrst, 2) |-> bclk != $past(bclk);
    endproperty
    a_bclk_div: assert property (p_bclk_div)
        else $error("bit clock not half rate");
    property p_strobe_edge;
        $changed(word_load_strobe) |-> $fell(bclk);
    endproperty
    a_strobe_edge: assert property (p_strobe_edge)
        else $error("strobe moved off clock fall");
    property p_data_edge;
        $changed(sdata) |-> $fell(bclk);
    endproperty
    a_data_edge: assert property (p_data_edge)
        else $error("data moved off clock fall");
    property p_hi_len;
        $fell(word_load_strobe) |-> hi_r == 8'h20;
    endproperty
    a_hi_len: assert property (p_hi_len)
        else $error("strobe high length wrong");
    property p_lo_min;
        $fell(word_load_strobe) |-> !word_load_strobe [*8];
    endproperty
    a_lo_min: assert property (p_lo_min)
        else $error("strobe low too short");
    property p_idle_zero;
        !word_load_strobe |-> !sdata;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("data not zero outside word");
    property p_open_sw;
        $fell(word_load_strobe) |-> !sample_left && !sample_right;
    endproperty
    a_open_sw: assert property (p_open_sw)
        else $error("switch closed at update");
    property p_settle;
        $rose(sample_left) || $rose(sample_right) |-> lo_r == 8'(SETTLE);
    endproperty
    a_settle: assert property (p_settle)
        else $error("switch settle delay wrong");
    property p_alt;
        $rose(sample_right) |-> left_last_r;
    endproperty
    a_alt: assert property (p_alt)
        else $error("channels not alternating");

    c_load: cover property ($fell(word_load_strobe));
    c_left: cover property ($rose(sample_left));
    c_right: cover property ($rose(sample_right));
endmodule

/* verif/tb.sv */
// Purpose: Self-checking bench for the serial word link
// Assumes: ce tied high; second link driven by the bench
// Notes:   Words checked in order at the converter end
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb import dac_link_pkg::*;;
    logic clk_sys, nrst, s_valid, s_ready, sample_left, sample_right;
    logic slot_busy, underrun, dac_update, refused;
    logic [WORD_W-1:0] s_data, dac_word, dac_word_2, exp_w;
    logic [WORD_W-1:0] exp_q[$];
    logic [WORD_W-1:0] codes[4] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff};
    int num_errors, n_tests, got, n_under, k;
    time t_first, t_last;

    dac_link_if link_bus ();
    dac_link_if link_bench ();

    dac_word_sender #(.DEPTH(FIFO_DEPTH), .SETTLE(SETTLE_CYC))
        u_dac_word_sender (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
        .sample_left(sample_left), .sample_right(sample_right),
        .slot_busy(slot_busy), .underrun(underrun), .link(link_bus.ctrl));
    dac_word_loader u_dac_word_loader (.link(link_bus.dac), .ce(1'b1),
        .dac_word(dac_word), .dac_update(dac_update));
    dac_word_loader u_dac_word_loader_2 (.link(link_bench.dac),
        .ce(1'b1), .dac_word(dac_word_2), .dac_update());
    dac_link_asserts #(.SETTLE(SETTLE_CYC)) u_dac_link_asserts (
        .clk_sys(clk_sys), .nrst(nrst), .bclk(link_bus.bclk),
        .word_load_strobe(link_bus.word_load_strobe),
        .sdata(link_bus.sdata), .sample_left(sample_left),
        .sample_right(sample_right));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Converter end monitor
    always @(negedge link_bus.bclk) begin
        if (dac_update === 1'b1) begin
            got++;
            t_last = $time;
            if (got == 1) t_first = $time;
            exp_w = exp_q.pop_front();
            `CHK("dac_word", exp_w, dac_word)
            `CHK("busy_slot", 1'b1, slot_busy)
        end
    end
    always @(negedge clk_sys) if (underrun === 1'b1) n_under++;

    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic put_word(input logic [WORD_W-1:0] w);
        @(negedge clk_sys);
        s_valid = 1'b1;
        s_data = w;
        exp_q.push_back(w);
        for (int i = 0; i < 200 && s_ready !== 1'b1; i++) begin
            refused = 1'b1;
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
    endtask

    // One bench bit clock period, 30 ns
    task automatic tick();
        #15 link_bench.bclk = 1'b1;
        #15 link_bench.bclk = 1'b0;
    endtask

    // Stopped clock word: strobe rises after the first edge
    task automatic bench_word(input logic [23:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            link_bench.sdata = v[i];
            tick();
            link_bench.word_load_strobe = 1'b1;
        end
        link_bench.word_load_strobe = 1'b0;
        link_bench.sdata = ~link_bench.sdata;
        tick();
        link_bench.sdata = ~link_bench.sdata;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        s_valid = 1'b0;
        s_data = '0;
        refused = 1'b0;
        link_bench.bclk = 1'b0;
        link_bench.word_load_strobe = 1'b0;
        link_bench.sdata = 1'b0;
        repeat (16) @(negedge clk_sys);
        `CHK("idle", 4'h0, {link_bus.bclk, link_bus.word_load_strobe,
            sample_left, sample_right})
        nrst = 1'b1;
        foreach (codes[i]) begin
            bench_word({8'h00, codes[i]}, 16);
            `CHK("word_2", codes[i], dac_word_2)
        end
        bench_word(24'h5abcde, 20);
        `CHK("last16", 16'hbcde, dac_word_2)
        repeat (20) begin
            link_bench.sdata = ~link_bench.sdata;
            tick();
        end
        `CHK("hold", 16'hbcde, dac_word_2)
        for (int i = 0; i < 10; i++) put_word(16'h8001 + 16'(i) * 16'h2f13);
        @(negedge clk_sys);
        s_valid = 1'b0;
        `CHK("refused", 1'b1, refused)
        for (k = 0; k < 3000 && got < 10; k++) @(negedge clk_sys);
        repeat (SETTLE_CYC + 40) @(negedge clk_sys);
        `CHK("count", 10, got)
        `CHK("period", 9 * SLOT_CYC * CLK_SYS_NS, t_last - t_first)
        `CHK("switches", 2'b01, {sample_left, sample_right})
        `CHK("underrun", 1'b1, n_under > 0)
        `CHK("busy", 1'b0, slot_busy)
        give_verdict();
    end

    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule
